//--- include/brsl_defines.svh
`ifndef BRSL_DEFINES_SVH
`define BRSL_DEFINES_SVH

// Register offsets
`define BRSL_ADDR_REGULATOR_OUTPUT_CONTROL 8'h1D
`define BRSL_ADDR_BUTTON_TIMER_CONTROL 8'h30
`define BRSL_ADDR_DEVICE_GLOBAL_CONTROL 8'h35
`define BRSL_ADDR_PRESS_ACTION_CONTROL 8'h36

// Reset values
`define BRSL_RST_REGULATOR_OUTPUT_CONTROL 8'hB0
`define BRSL_RST_BUTTON_TIMER_CONTROL 8'h2A
`define BRSL_RST_DEVICE_GLOBAL_CONTROL 8'h10
`define BRSL_RST_PRESS_ACTION_CONTROL 8'h00

// Regulator output control fields
`define BRSL_BIT_STAGE_ENABLE 7
`define BRSL_MSB_VOLTAGE_CODE 6
`define BRSL_LSB_VOLTAGE_CODE 2
`define BRSL_BIT_SWITCH_SELECT 1

// Button timer control fields
`define BRSL_BIT_SUPPLY_GATE 7
`define BRSL_BIT_WAKE1_SEL 6
`define BRSL_BIT_WAKE2_SEL 5
`define BRSL_MSB_WARN_OFFSET 4
`define BRSL_LSB_WARN_OFFSET 3
`define BRSL_MSB_HOLD_SEL 2
`define BRSL_LSB_HOLD_SEL 1

// Device global control fields
`define BRSL_BIT_SHIP_ENABLE 7
`define BRSL_MSB_RESTART_SEL 5
`define BRSL_LSB_RESTART_SEL 4
`define BRSL_BIT_GLOBAL_MASK 2
`define BRSL_BIT_POWER_CYCLE_REQ 1
`define BRSL_BIT_DEFAULT_REQ 0

// Press action control field
`define BRSL_MSB_LONG_ACTION 7
`define BRSL_LSB_LONG_ACTION 6

// Regulator voltage in millivolts
`define BRSL_VOLT_BASE_MV 12'h258
`define BRSL_VOLT_STEP_MV 12'h064

// Hold and delay times in milliseconds
`define BRSL_WAKE1_SHORT_MS 14'h007D
`define BRSL_WAKE1_LONG_MS 14'h01F4
`define BRSL_WAKE2_SHORT_MS 14'h03E8
`define BRSL_WAKE2_LONG_MS 14'h07D0
`define BRSL_HOLD_4S_MS 14'h0FA0
`define BRSL_HOLD_8S_MS 14'h1F40
`define BRSL_HOLD_10S_MS 14'h2710
`define BRSL_HOLD_14S_MS 14'h36B0
`define BRSL_WARN_STEP_MS 14'h01F4
`define BRSL_RESTART_0P6_MS 14'h0258
`define BRSL_RESTART_1P2_MS 14'h04B0
`define BRSL_RESTART_2P4_MS 14'h0960
`define BRSL_RESTART_5_MS 14'h1388
`define BRSL_BRIEF_OFF_MS 14'h0002

// Millisecond tick: one millisecond over the clock period
`define BRSL_MS_NS 1000000
`define BRSL_CLK_NS 10
`define BRSL_TICK_CYCLES (`BRSL_MS_NS / `BRSL_CLK_NS)

`endif

//--- include/brsl_pkg.sv
`default_nettype none
package brsl_pkg;
   // Drive bundle toward the output stage
   typedef struct packed {
      logic enable;
      logic switch_mode;
      logic [4:0] code;
      logic [11:0] target_mv;
   } brsl_stage_t;
   // One-cycle button events
   typedef struct packed {
      logic wake1;
      logic wake2;
      logic warn;
   } brsl_button_ev_t;
   // Power sequencing states
   typedef enum logic [1:0] {
      ST_RUN = 2'h0,
      ST_RAIL_OFF = 2'h1
   } brsl_state_t;
endpackage
`default_nettype wire

//--- hw/brsl_ctrl.sv
// Operation
// - Enable bit switches output stage; resets on
// - Target is 600 mV plus code times 100
// - Select bit zero regulator, one load switch
// - Gate bit adds valid supply to reset
// - First wake hold 125 or 500 ms
// - Second wake hold 1 or 2 s
// - Reset hold 4, 8, 10 or 14 s
// - Warning at reset hold minus offset
// - Ship mode: enabled, no supply, button high
// - Restart after press reset by chosen delay
// - Global mask suppresses the interrupt output
// - Power cycle bit drops rails, restores defaults
// - Default bit restores registers, rails stay up
// - Long press: power cycle, nothing, or ship
`timescale 1ns/1ps
`include "brsl_defines.svh"
`default_nettype none
module brsl_ctrl #(
   parameter int TICK_CYCLES = `BRSL_TICK_CYCLES
) (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   input wire logic PUSHBUTTON_INPUT_N,
   input wire logic SUPPLY_VALID,
   input wire logic INT_REQUEST,
   output logic INT_OUT,
   output brsl_pkg::brsl_stage_t OUTPUT_STAGE,
   output brsl_pkg::brsl_button_ev_t BUTTON_EVENT,
   output logic RAIL_POWER_DOWN,
   output logic SHIP_MODE
);
   import brsl_pkg::*;

   // Hold time for the reset field
   function automatic logic [13:0] hold_ms(input logic [1:0] sel);
      case (sel)
         2'h0: hold_ms = `BRSL_HOLD_4S_MS;
         2'h1: hold_ms = `BRSL_HOLD_8S_MS;
         2'h2: hold_ms = `BRSL_HOLD_10S_MS;
         default: hold_ms = `BRSL_HOLD_14S_MS;
      endcase
   endfunction

   // Restart delay for the auto-wake field
   function automatic logic [13:0] restart_ms(input logic [1:0] sel);
      case (sel)
         2'h0: restart_ms = `BRSL_RESTART_0P6_MS;
         2'h1: restart_ms = `BRSL_RESTART_1P2_MS;
         2'h2: restart_ms = `BRSL_RESTART_2P4_MS;
         default: restart_ms = `BRSL_RESTART_5_MS;
      endcase
   endfunction

   logic [1:0] btn_sync; // Button synchroniser
   logic [1:0] vin_sync; // Supply-valid synchroniser
   logic [16:0] tick_cnt; // Millisecond divider
   logic [16:0] next_tick_cnt;
   logic tick; // One-cycle millisecond enable
   logic [7:0] regulator_output_control;
   logic [7:0] button_timer_control;
   logic [7:0] device_global_control;
   logic [7:0] press_action_control;
   logic [7:0] next_regulator_output_control;
   logic [7:0] next_button_timer_control;
   logic [7:0] next_device_global_control;
   logic [7:0] next_press_action_control;
   logic [13:0] press_ms; // Time held so far
   logic [13:0] next_press_ms;
   logic [13:0] off_ms; // Time spent with rails down
   logic [13:0] next_off_ms;
   logic [13:0] off_target; // Length of this power-down
   logic [13:0] next_off_target;
   brsl_state_t state;
   brsl_state_t next_state;
   logic ship_latched; // Ship mode entered by long press
   logic next_ship_latched;
   brsl_button_ev_t next_event;
   logic [7:0] next_rdata;
   logic pressed; // Synchronised button is low
   logic supply_ok; // Synchronised supply valid
   logic [13:0] step_ms; // Press time after this tick
   logic [13:0] reset_hold; // Selected reset hold time
   logic [13:0] warn_at; // Warning point
   logic [4:0] code; // Voltage code field

   // Two flops on the button and supply pins before any logic looks at them
   always_ff @(posedge CLK) begin
      if (SRST) begin
         btn_sync <= 2'h3;
         vin_sync <= 2'h0;
      end else begin
         btn_sync <= {btn_sync[0], PUSHBUTTON_INPUT_N};
         vin_sync <= {vin_sync[0], SUPPLY_VALID};
      end
   end
   assign pressed = ~btn_sync[1];
   assign supply_ok = vin_sync[1];

   // Millisecond divider next value
   always_comb begin
      if (tick_cnt == 17'(TICK_CYCLES - 1)) begin
         next_tick_cnt = 17'h0;
      end else begin
         next_tick_cnt = tick_cnt + 17'h1;
      end
   end
   assign tick = (tick_cnt == 17'(TICK_CYCLES - 1));

   // Millisecond divider register
   always_ff @(posedge CLK) begin
      if (SRST) begin
         tick_cnt <= 17'h0;
      end else begin
         tick_cnt <= next_tick_cnt;
      end
   end

   // Field decode shared by timing and outputs
   assign code = regulator_output_control[`BRSL_MSB_VOLTAGE_CODE:
                                          `BRSL_LSB_VOLTAGE_CODE];
   assign reset_hold = hold_ms(button_timer_control[`BRSL_MSB_HOLD_SEL:
                                                    `BRSL_LSB_HOLD_SEL]);
   assign warn_at = reset_hold - 14'(({12'h0, button_timer_control[
      `BRSL_MSB_WARN_OFFSET:`BRSL_LSB_WARN_OFFSET]} + 14'h1)
      * `BRSL_WARN_STEP_MS);
   assign step_ms = press_ms + 14'h1;

   // Registers, button timing and power sequencing
   always_comb begin
      next_regulator_output_control = regulator_output_control;
      next_button_timer_control = button_timer_control;
      next_device_global_control = device_global_control;
      next_press_action_control = press_action_control;
      next_press_ms = press_ms;
      next_off_ms = off_ms;
      next_off_target = off_target;
      next_state = state;
      next_ship_latched = ship_latched;
      next_event = '0;
      next_rdata = 8'h00;
      // Read mux, unmapped addresses read zero
      if (REG_RD) begin
         case (REG_ADDR)
            `BRSL_ADDR_REGULATOR_OUTPUT_CONTROL:
               next_rdata = regulator_output_control;
            `BRSL_ADDR_BUTTON_TIMER_CONTROL:
               next_rdata = button_timer_control;
            `BRSL_ADDR_DEVICE_GLOBAL_CONTROL:
               next_rdata = device_global_control;
            `BRSL_ADDR_PRESS_ACTION_CONTROL:
               next_rdata = press_action_control;
            default: next_rdata = 8'h00;
         endcase
      end
      // Register writes
      if (REG_WR) begin
         case (REG_ADDR)
            `BRSL_ADDR_REGULATOR_OUTPUT_CONTROL:
               next_regulator_output_control = REG_WDATA;
            `BRSL_ADDR_BUTTON_TIMER_CONTROL:
               next_button_timer_control = REG_WDATA;
            `BRSL_ADDR_DEVICE_GLOBAL_CONTROL:
               next_device_global_control = REG_WDATA;
            `BRSL_ADDR_PRESS_ACTION_CONTROL:
               next_press_action_control = REG_WDATA;
            default: next_rdata = next_rdata;
         endcase
      end
      case (state)
         ST_RUN: begin
            // Press timer runs only while held
            if (!pressed) begin
               next_press_ms = 14'h0;
            end else if (tick && press_ms != 14'h3FFF) begin
               next_press_ms = step_ms;
               next_event.wake1 = (step_ms ==
                  (button_timer_control[`BRSL_BIT_WAKE1_SEL] ?
                  `BRSL_WAKE1_LONG_MS : `BRSL_WAKE1_SHORT_MS));
               next_event.wake2 = (step_ms ==
                  (button_timer_control[`BRSL_BIT_WAKE2_SEL] ?
                  `BRSL_WAKE2_LONG_MS : `BRSL_WAKE2_SHORT_MS));
               next_event.warn = (step_ms == warn_at);
               // Reset hold met, optionally gated by supply
               if (step_ms == reset_hold && (supply_ok ||
                   !button_timer_control[`BRSL_BIT_SUPPLY_GATE])) begin
                  case (press_action_control[`BRSL_MSB_LONG_ACTION:
                                             `BRSL_LSB_LONG_ACTION])
                     2'h0: begin
                        next_state = ST_RAIL_OFF;
                        next_off_ms = 14'h0;
                        next_off_target = restart_ms(device_global_control[
                           `BRSL_MSB_RESTART_SEL:`BRSL_LSB_RESTART_SEL]);
                     end
                     2'h1: next_ship_latched = ship_latched;
                     default: next_ship_latched = 1'b1;
                  endcase
               end
            end
            // Register-requested power cycle
            if (REG_WR && REG_ADDR == `BRSL_ADDR_DEVICE_GLOBAL_CONTROL &&
                REG_WDATA[`BRSL_BIT_POWER_CYCLE_REQ]) begin
               next_state = ST_RAIL_OFF;
               next_off_ms = 14'h0;
               next_off_target = `BRSL_BRIEF_OFF_MS;
            end
         end
         ST_RAIL_OFF: begin
            // Rails held down, events abandoned
            next_press_ms = 14'h0;
            if (tick) begin
               next_off_ms = off_ms + 14'h1;
               if (off_ms + 14'h1 >= off_target) begin
                  next_state = ST_RUN;
               end
            end
         end
         default: next_state = ST_RUN;
      endcase
      // Entering a power cycle or a default request restores defaults
      if ((next_state == ST_RAIL_OFF && state == ST_RUN) ||
          (REG_WR && REG_ADDR == `BRSL_ADDR_DEVICE_GLOBAL_CONTROL &&
           REG_WDATA[`BRSL_BIT_DEFAULT_REQ])) begin
         next_regulator_output_control = `BRSL_RST_REGULATOR_OUTPUT_CONTROL;
         next_button_timer_control = `BRSL_RST_BUTTON_TIMER_CONTROL;
         next_device_global_control = `BRSL_RST_DEVICE_GLOBAL_CONTROL;
         next_press_action_control = `BRSL_RST_PRESS_ACTION_CONTROL;
         next_ship_latched = 1'b0;
      end
   end

   // Register group storage
   always_ff @(posedge CLK) begin
      if (SRST) begin
         regulator_output_control <= `BRSL_RST_REGULATOR_OUTPUT_CONTROL;
         button_timer_control <= `BRSL_RST_BUTTON_TIMER_CONTROL;
         device_global_control <= `BRSL_RST_DEVICE_GLOBAL_CONTROL;
         press_action_control <= `BRSL_RST_PRESS_ACTION_CONTROL;
         press_ms <= 14'h0;
         off_ms <= 14'h0;
         off_target <= 14'h0;
         state <= ST_RUN;
         ship_latched <= 1'b0;
         BUTTON_EVENT <= '0;
         REG_RDATA <= 8'h00;
      end else begin
         regulator_output_control <= next_regulator_output_control;
         button_timer_control <= next_button_timer_control;
         device_global_control <= next_device_global_control;
         press_action_control <= next_press_action_control;
         press_ms <= next_press_ms;
         off_ms <= next_off_ms;
         off_target <= next_off_target;
         state <= next_state;
         ship_latched <= next_ship_latched;
         BUTTON_EVENT <= next_event;
         REG_RDATA <= next_rdata;
      end
   end

   // Output stage drive, all from register bits
   always_comb begin
      OUTPUT_STAGE.enable =
         regulator_output_control[`BRSL_BIT_STAGE_ENABLE];
      OUTPUT_STAGE.switch_mode =
         regulator_output_control[`BRSL_BIT_SWITCH_SELECT];
      OUTPUT_STAGE.code = code;
      OUTPUT_STAGE.target_mv = `BRSL_VOLT_BASE_MV +
         12'({7'h0, code} * `BRSL_VOLT_STEP_MV);
   end

   // Rails, ship mode and interrupt gating
   assign RAIL_POWER_DOWN = (state == ST_RAIL_OFF);
   assign SHIP_MODE = ship_latched ||
      (device_global_control[`BRSL_BIT_SHIP_ENABLE] && !supply_ok &&
       !pressed);
   assign INT_OUT = INT_REQUEST &&
      !device_global_control[`BRSL_BIT_GLOBAL_MASK];
endmodule
`default_nettype wire

//--- verification/brsl_host.sv
`timescale 1ns/1ps
`default_nettype none
// Register-bus master standing in for the serial front end
module brsl_host (
   input wire logic clk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // Idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'hFF;
      reg_wdata = 8'hFF;
   end
   // One write strobe; released fields show the inverse, not stale data
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
   endtask
   // One read strobe; data taken in the answer cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask
endmodule
`default_nettype wire

//--- verification/brsl_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the control block
module brsl_ctrl_props
   import brsl_pkg::*;
#(
   parameter int TICK_CYCLES = 10
) (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [7:0] REG_RDATA,
   input wire logic PUSHBUTTON_INPUT_N,
   input wire logic SUPPLY_VALID,
   input wire logic INT_REQUEST,
   input wire logic INT_OUT,
   input wire brsl_stage_t OUTPUT_STAGE,
   input wire brsl_button_ev_t BUTTON_EVENT,
   input wire logic RAIL_POWER_DOWN,
   input wire logic SHIP_MODE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   logic [7:0] wd_q; // Write data one cycle back
   // Keeps the written byte for the following cycle
   always_ff @(posedge CLK) begin
      wd_q <= REG_WDATA;
   end
   int_pass_a: assert property (
      INT_OUT |-> INT_REQUEST) else $error("interrupt without request");
   int_mask_a: assert property (
      REG_WR && REG_ADDR == 8'h35 && REG_WDATA[2] && REG_WDATA[1:0] == 2'h0
      |=> !INT_OUT) else $error("masked interrupt delivered");
   int_clear_a: assert property (
      REG_WR && REG_ADDR == 8'h35 && !REG_WDATA[2]
      |=> INT_OUT == INT_REQUEST) else $error("interrupt not delivered");
   stage_mv_a: assert property (
      OUTPUT_STAGE.target_mv == 12'h258 + 12'(OUTPUT_STAGE.code) * 12'h064)
      else $error("target voltage wrong");
   stage_write_a: assert property (
      REG_WR && REG_ADDR == 8'h1D |=> OUTPUT_STAGE.enable == wd_q[7] &&
      OUTPUT_STAGE.code == wd_q[6:2] && OUTPUT_STAGE.switch_mode == wd_q[1])
      else $error("output stage not from written byte");
   default_req_a: assert property (
      REG_WR && REG_ADDR == 8'h35 && REG_WDATA[1:0] == 2'h1
      |=> OUTPUT_STAGE.code == 5'h0C && OUTPUT_STAGE.enable &&
      !OUTPUT_STAGE.switch_mode && !$rose(RAIL_POWER_DOWN))
      else $error("default request wrong");
   power_cycle_a: assert property (
      REG_WR && REG_ADDR == 8'h35 && REG_WDATA[1]
      |=> RAIL_POWER_DOWN && OUTPUT_STAGE.code == 5'h0C)
      else $error("power cycle request wrong");
   event_press_a: assert property (
      |BUTTON_EVENT |-> !$past(PUSHBUTTON_INPUT_N, 8))
      else $error("button event without press");
   event_pulse_a: assert property (
      |BUTTON_EVENT |=> BUTTON_EVENT == 3'h0) else $error("event too long");
   ship_entry_a: assert property (
      REG_WR && REG_ADDR == 8'h35 && REG_WDATA[7] && REG_WDATA[1:0] == 2'h0
      ##1 (!SUPPLY_VALID && PUSHBUTTON_INPUT_N && !REG_WR) [*3]
      |-> SHIP_MODE) else $error("ship mode not entered");
endmodule
bind brsl_ctrl brsl_ctrl_props #(.TICK_CYCLES(TICK_CYCLES)) i_brsl_ctrl_props (
   .CLK(CLK), .SRST(SRST), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .PUSHBUTTON_INPUT_N(PUSHBUTTON_INPUT_N), .SUPPLY_VALID(SUPPLY_VALID),
   .INT_REQUEST(INT_REQUEST), .INT_OUT(INT_OUT),
   .OUTPUT_STAGE(OUTPUT_STAGE), .BUTTON_EVENT(BUTTON_EVENT),
   .RAIL_POWER_DOWN(RAIL_POWER_DOWN), .SHIP_MODE(SHIP_MODE));
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import brsl_pkg::*;
   localparam int TK = 5; // Shortened millisecond tick
   logic clk, srst, pb_n, sup_ok, int_req, rail_q;
   wire logic wr, rd, int_out, rail, ship;
   wire logic [7:0] addr, wdata, rdata;
   brsl_stage_t stage; // Output stage bundle
   brsl_button_ev_t ev; // Button event pulses
   int n_mismatch, comparisons, cyc, t0, t_w1, t_w2, t_wn, t_dn, t_up;
   logic [7:0] d; // Read data
   logic [7:0] ra [5] = '{8'h1D, 8'h30, 8'h35, 8'h36, 8'h00};
   logic [7:0] rv [5] = '{8'hB0, 8'h2A, 8'h10, 8'h00, 8'h00};
   brsl_ctrl #(.TICK_CYCLES(TK)) i_brsl_ctrl (.CLK(clk), .SRST(srst),
      .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_RDATA(rdata), .PUSHBUTTON_INPUT_N(pb_n), .SUPPLY_VALID(sup_ok),
      .INT_REQUEST(int_req), .INT_OUT(int_out), .OUTPUT_STAGE(stage),
      .BUTTON_EVENT(ev), .RAIL_POWER_DOWN(rail), .SHIP_MODE(ship));
   brsl_host i_brsl_host (.clk(clk), .reg_wr(wr), .reg_rd(rd),
      .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Cycle count and the moment of each event or rail edge
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (ev.wake1) t_w1 <= cyc;
      if (ev.wake2) t_w2 <= cyc;
      if (ev.warn) t_wn <= cyc;
      if (rail && !rail_q) t_dn <= cyc;
      if (!rail && rail_q) t_up <= cyc;
      rail_q <= rail;
   end
   // Value comparison
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Cycles after press against a time in ms, with tick jitter allowed
   task automatic chk_t(input int got, input int ms, input int slack);
      comparisons++;
      if (got < (ms - 1) * TK || got > ms * TK + slack * TK + 4) begin
         n_mismatch++;
         $display("[ERR] %0t event after %0d cycles, not %0d ms", $time,
            got, ms);
      end
   endtask
   // Press the button, forget earlier events, hold, release
   task automatic press(input int ms);
      @(posedge clk);
      pb_n <= 1'b0;
      t0 = cyc;
      t_w1 = -1;
      t_w2 = -1;
      t_wn = -1;
      t_dn = -1;
      t_up = -1;
      repeat (ms * TK) @(posedge clk);
      pb_n <= 1'b1;
   endtask
   // Verdict and end of run
   task automatic wrap_up();
      if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence
   initial begin
      srst = 1'b1;
      pb_n = 1'b1;
      sup_ok = 1'b1;
      int_req = 1'b0;
      rail_q = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      cyc = 0;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      // Reset values, unmapped address reads zero
      for (int i = 0; i < 5; i++) begin
         i_brsl_host.rd(ra[i], d);
         chk(d, rv[i]);
      end
      chk(stage.target_mv, 16'h0708);
      // Every voltage code, with enable and select toggled
      for (int c = 0; c < 32; c++) begin
         i_brsl_host.wr(8'h1D, {c[0], c[4:0], c[1], 1'b0});
         chk(stage.target_mv, 16'h0258 + 16'(c) * 16'h0064);
         chk(stage.enable, c[0]);
         chk(stage.switch_mode, c[1]);
      end
      // Global interrupt mask
      @(posedge clk);
      int_req <= 1'b1;
      i_brsl_host.wr(8'h35, 8'h14);
      chk(int_out, 1'b0);
      i_brsl_host.wr(8'h35, 8'h10);
      chk(int_out, 1'b1);
      // Ship mode: enabled, supply invalid, button high
      @(posedge clk);
      sup_ok <= 1'b0;
      i_brsl_host.wr(8'h35, 8'h90);
      repeat (4) @(posedge clk);
      #1 chk(ship, 1'b1);
      i_brsl_host.wr(8'h35, 8'h10);
      chk(ship, 1'b0);
      @(posedge clk);
      sup_ok <= 1'b1;
      // Default request restores registers, rails stay up
      i_brsl_host.wr(8'h30, 8'hFF);
      i_brsl_host.wr(8'h1D, 8'h00);
      i_brsl_host.wr(8'h35, 8'h11);
      chk(rail, 1'b0);
      for (int i = 0; i < 3; i++) begin
         i_brsl_host.rd(ra[i], d);
         chk(d, rv[i]);
      end
      // Power cycle request: brief rail drop and defaults
      i_brsl_host.wr(8'h30, 8'hFF);
      i_brsl_host.wr(8'h35, 8'h12);
      i_brsl_host.rd(8'h30, d);
      chk(d, 8'h2A);
      i_brsl_host.rd(8'h35, d);
      chk(d, 8'h10);
      chk(rail, 1'b1);
      repeat (2 * TK) @(posedge clk);
      #1 chk(rail, 1'b0);
      // Early release: first wake seen, later events dropped
      i_brsl_host.wr(8'h30, 8'h00);
      press(300);
      repeat (1200 * TK) @(posedge clk);
      chk_t(t_w1 - t0, 125, 1);
      chk(t_w2 < 0 && t_wn < 0 && t_dn < 0, 1'b1);
      // Full press: power-cycle action, long wake holds, 1.2 s restart
      i_brsl_host.wr(8'h30, 8'h60);
      press(4100);
      repeat (1200 * TK) @(posedge clk);
      chk_t(t_w1 - t0, 500, 1);
      chk_t(t_w2 - t0, 2000, 1);
      chk_t(t_wn - t0, 3500, 1);
      chk_t(t_dn - t0, 4000, 1);
      chk_t(t_up - t0, 5200, 2);
      i_brsl_host.rd(8'h30, d);
      chk(d, 8'h2A);
      // Gated reset: supply invalid, so the hold brings no power cycle
      @(posedge clk);
      sup_ok <= 1'b0;
      i_brsl_host.wr(8'h30, 8'h80);
      press(4010);
      chk_t(t_wn - t0, 3500, 1);
      chk(t_dn < 0 && rail == 1'b0, 1'b1);
      @(posedge clk);
      sup_ok <= 1'b1;
      // Long press entering ship mode, warning 2 s early
      i_brsl_host.wr(8'h30, 8'h18);
      i_brsl_host.wr(8'h36, 8'h80);
      press(4050);
      chk_t(t_wn - t0, 2000, 1);
      chk(ship, 1'b1);
      chk(rail, 1'b0);
      i_brsl_host.wr(8'h35, 8'h11);
      chk(ship, 1'b0);
      wrap_up();
   end
   // Watchdog against a hang
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
endmodule
`default_nettype wire
